// File: design/pipb_pkg.sv
/*
  Constants for the peripheral interrupt priority-select register.
  Assumes one system clock and an active-low asynchronous reset.
*/
// Behaviour
// - Bit 3 selects conversion-complete priority level
// - Bit 2 selects window-compare priority level
// - Bit 1 selects USB function priority level
// - Bit 0 selects SMBus port priority level
// - Set counter-array bit means high priority
// - Bit 4 is counter-array; clear means low
package pipb_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NSRC = 5;

    // Register offsets, placed freely
    localparam logic [ADDR_W-1:0] PRIO_SEL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] PRIO_STAT_OFS = 8'h04;

    // Field positions
    localparam int SMBUS_BIT = 0;
    localparam int USB_BIT = 1;
    localparam int WIN_BIT = 2;
    localparam int CONV_BIT = 3;
    localparam int PCA_BIT = 4;

    localparam logic [NSRC-1:0] PRIO_SEL_RST = 5'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_RD = 8'h00;

    typedef enum logic {
        PIPB_LOW,
        PIPB_HIGH
    } pipb_level_t;

endpackage

// File: design/pipb_level_map.sv
/*
  Maps one priority-select bit to a priority level.
  Assumes the bit comes from a register on the same clock.
*/
`timescale 1ns/100ps
module pipb_level_map
    import pipb_pkg::*;
(
    input wire logic sel_i,
    output pipb_pkg::pipb_level_t level_o
);

    // Zero is low, one is high, for every source
    assign level_o = sel_i ? PIPB_HIGH : PIPB_LOW;

endmodule

// File: design/pipb_top.sv
/*
  Priority-select register for five peripheral interrupt sources.
  Assumes a simple software port and an arbiter outside that reads
  the per-source high-priority outputs.
*/
`timescale 1ns/100ps
module pipb_top
    import pipb_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [pipb_pkg::ADDR_W-1:0] addr_i,
    input wire logic [pipb_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [pipb_pkg::DATA_W-1:0] rdata_o,
    output logic counter_array_prio_sel_o,
    output logic conv_done_prio_sel_o,
    output logic window_cmp_prio_sel_o,
    output logic usb_func_prio_sel_o,
    output logic smbus_port_prio_sel_o
);

    ////////////////////////////////////////////////////////////////
    // Select bits, one flop per source
    logic counter_array_sel_q;
    logic counter_array_sel_d;
    logic conv_done_sel_q;
    logic conv_done_sel_d;
    logic window_cmp_sel_q;
    logic window_cmp_sel_d;
    logic usb_func_sel_q;
    logic usb_func_sel_d;
    logic smbus_port_sel_q;
    logic smbus_port_sel_d;

    // Level stage; costs a cycle but keeps outputs on flops
    logic counter_array_high_q;
    logic counter_array_high_d;
    logic conv_done_high_q;
    logic conv_done_high_d;
    logic window_cmp_high_q;
    logic window_cmp_high_d;
    logic usb_func_high_q;
    logic usb_func_high_d;
    logic smbus_port_high_q;
    logic smbus_port_high_d;

    // Levels as mapped from the select bits
    pipb_level_t counter_array_lvl;
    pipb_level_t conv_done_lvl;
    pipb_level_t window_cmp_lvl;
    pipb_level_t usb_func_lvl;
    pipb_level_t smbus_port_lvl;

    // Bus decode and read path
    logic sel_wr;
    logic sel_rd;
    logic stat_rd;
    logic miss_rd;
    wire logic [NSRC-1:0] sel_vec;
    wire logic [NSRC-1:0] high_vec;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    ////////////////////////////////////////////////////////////////
    // Address compare, shared by write and read decode
    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    // Widen five bits to a bus word; upper bits read zero
    function automatic logic [DATA_W-1:0] pack_word(
        input logic [NSRC-1:0] bits
    );
        logic [DATA_W-1:0] word;
        word = '0;
        word[NSRC-1:0] = bits;
        return word;
    endfunction

    // One select bit: new data on a hit, else hold
    function automatic logic next_sel(
        input logic hit,
        input logic new_bit,
        input logic old_bit
    );
        return hit ? new_bit : old_bit;
    endfunction

    // Level to high-priority flag
    function automatic logic is_high(
        input pipb_level_t lvl
    );
        return lvl == PIPB_HIGH;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Strobes never come together; decoded apart anyway
    assign sel_wr = wr_i && addr_hit(addr_i, PRIO_SEL_OFS);
    assign sel_rd = rd_i && addr_hit(addr_i, PRIO_SEL_OFS);
    assign stat_rd = rd_i && addr_hit(addr_i, PRIO_STAT_OFS);
    assign miss_rd = rd_i && !sel_rd && !stat_rd;

    // Bits 7:5 of a write are dropped; unmapped writes hold all
    assign counter_array_sel_d = next_sel(sel_wr, wdata_i[PCA_BIT],
        counter_array_sel_q);
    assign conv_done_sel_d = next_sel(sel_wr, wdata_i[CONV_BIT],
        conv_done_sel_q);
    assign window_cmp_sel_d = next_sel(sel_wr, wdata_i[WIN_BIT],
        window_cmp_sel_q);
    assign usb_func_sel_d = next_sel(sel_wr, wdata_i[USB_BIT],
        usb_func_sel_q);
    assign smbus_port_sel_d = next_sel(sel_wr, wdata_i[SMBUS_BIT],
        smbus_port_sel_q);

    ////////////////////////////////////////////////////////////////
    pipb_level_map u_counter_array_map (
        .sel_i(counter_array_sel_q),
        .level_o(counter_array_lvl)
    );

    pipb_level_map u_conv_done_map (
        .sel_i(conv_done_sel_q),
        .level_o(conv_done_lvl)
    );

    pipb_level_map u_window_cmp_map (
        .sel_i(window_cmp_sel_q),
        .level_o(window_cmp_lvl)
    );

    pipb_level_map u_usb_func_map (
        .sel_i(usb_func_sel_q),
        .level_o(usb_func_lvl)
    );

    pipb_level_map u_smbus_port_map (
        .sel_i(smbus_port_sel_q),
        .level_o(smbus_port_lvl)
    );

    assign counter_array_high_d = is_high(counter_array_lvl);
    assign conv_done_high_d = is_high(conv_done_lvl);
    assign window_cmp_high_d = is_high(window_cmp_lvl);
    assign usb_func_high_d = is_high(usb_func_lvl);
    assign smbus_port_high_d = is_high(smbus_port_lvl);

    // Software sees the bits in register order
    assign sel_vec[PCA_BIT] = counter_array_sel_q;
    assign sel_vec[CONV_BIT] = conv_done_sel_q;
    assign sel_vec[WIN_BIT] = window_cmp_sel_q;
    assign sel_vec[USB_BIT] = usb_func_sel_q;
    assign sel_vec[SMBUS_BIT] = smbus_port_sel_q;
    assign high_vec[PCA_BIT] = counter_array_high_q;
    assign high_vec[CONV_BIT] = conv_done_high_q;
    assign high_vec[WIN_BIT] = window_cmp_high_q;
    assign high_vec[USB_BIT] = usb_func_high_q;
    assign high_vec[SMBUS_BIT] = smbus_port_high_q;

    // Registered read data stands one cycle only
    assign rdata_d = sel_rd ? pack_word(sel_vec) :
                     stat_rd ? pack_word(high_vec) :
                     miss_rd ? UNMAPPED_RD : '0;

    ////////////////////////////////////////////////////////////////
    // Select register, one flop per source
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            counter_array_sel_q <= PRIO_SEL_RST[PCA_BIT];
        end
        else
        begin
            counter_array_sel_q <= counter_array_sel_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            conv_done_sel_q <= PRIO_SEL_RST[CONV_BIT];
        end
        else
        begin
            conv_done_sel_q <= conv_done_sel_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            window_cmp_sel_q <= PRIO_SEL_RST[WIN_BIT];
        end
        else
        begin
            window_cmp_sel_q <= window_cmp_sel_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            usb_func_sel_q <= PRIO_SEL_RST[USB_BIT];
        end
        else
        begin
            usb_func_sel_q <= usb_func_sel_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            smbus_port_sel_q <= PRIO_SEL_RST[SMBUS_BIT];
        end
        else
        begin
            smbus_port_sel_q <= smbus_port_sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Level stage, one flop per source
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            counter_array_high_q <= PRIO_SEL_RST[PCA_BIT];
        end
        else
        begin
            counter_array_high_q <= counter_array_high_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            conv_done_high_q <= PRIO_SEL_RST[CONV_BIT];
        end
        else
        begin
            conv_done_high_q <= conv_done_high_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            window_cmp_high_q <= PRIO_SEL_RST[WIN_BIT];
        end
        else
        begin
            window_cmp_high_q <= window_cmp_high_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            usb_func_high_q <= PRIO_SEL_RST[USB_BIT];
        end
        else
        begin
            usb_func_high_q <= usb_func_high_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            smbus_port_high_q <= PRIO_SEL_RST[SMBUS_BIT];
        end
        else
        begin
            smbus_port_high_q <= smbus_port_high_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data, zero whenever no read was taken
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Levels lag the select bits by one cycle
    assign rdata_o = rdata_q;
    assign counter_array_prio_sel_o = counter_array_high_q;
    assign conv_done_prio_sel_o = conv_done_high_q;
    assign window_cmp_prio_sel_o = window_cmp_high_q;
    assign usb_func_prio_sel_o = usb_func_high_q;
    assign smbus_port_prio_sel_o = smbus_port_high_q;

endmodule

// File: verif/pipb_top_sva.sv
/* Checker on pipb_top ports.
   Assumes binding to pipb_top; strobes one cycle long. */
`timescale 1ns/100ps
module pipb_top_sva(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic counter_array_prio_sel_o,
    input wire logic conv_done_prio_sel_o,
    input wire logic window_cmp_prio_sel_o,
    input wire logic usb_func_prio_sel_o,
    input wire logic smbus_port_prio_sel_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    wire w = wr_i && addr_i == 8'h00;
    wire r = rd_i && addr_i == 8'h00;
    wire m = rd_i && addr_i != 8'h00 && addr_i != 8'h04;
    a_rd_sel_match: assert property (r |=> rdata_o == {3'h0,
        counter_array_prio_sel_o, conv_done_prio_sel_o,
        window_cmp_prio_sel_o, usb_func_prio_sel_o,
        smbus_port_prio_sel_o}) else $error("select readback");
    a_rd_unmapped: assert property (m |=> rdata_o == 8'h00)
        else $error("unmapped rdata");
    a_pca_lvl: assert property (w |-> ##2
        counter_array_prio_sel_o == $past(wdata_i[4], 2)) else $error("pca");
    a_conv_lvl: assert property (w |-> ##2
        conv_done_prio_sel_o == $past(wdata_i[3], 2)) else $error("conv");
    a_win_lvl: assert property (w |-> ##2
        window_cmp_prio_sel_o == $past(wdata_i[2], 2)) else $error("win");
    a_usb_lvl: assert property (w |-> ##2
        usb_func_prio_sel_o == $past(wdata_i[1], 2)) else $error("usb");
    a_smb_lvl: assert property (w |-> ##2
        smbus_port_prio_sel_o == $past(wdata_i[0], 2)) else $error("smb");
    a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("idle rdata");
endmodule
bind pipb_top pipb_top_sva u_pipb_top_sva(
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .counter_array_prio_sel_o(counter_array_prio_sel_o),
    .conv_done_prio_sel_o(conv_done_prio_sel_o),
    .window_cmp_prio_sel_o(window_cmp_prio_sel_o),
    .usb_func_prio_sel_o(usb_func_prio_sel_o),
    .smbus_port_prio_sel_o(smbus_port_prio_sel_o)
);

// File: verif/pipb_top_bench.sv
/* Bench for pipb_top.
   Assumes mirror at 8'h04 returns the levels in bits 4:0. */
`timescale 1ns/100ps
module pipb_top_bench;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic rd_q = 1'b0, wr_q1 = 1'b0, wr_q2 = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, d, q[$];
    logic [4:0] lq[$];
    wire [7:0] rdata_o;
    wire [4:0] p;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    pipb_top u_pipb_top(.ref_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .counter_array_prio_sel_o(p[4]),
        .conv_done_prio_sel_o(p[3]), .window_cmp_prio_sel_o(p[2]),
        .usb_func_prio_sel_o(p[1]), .smbus_port_prio_sel_o(p[0]));
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    task bus(input logic w, r, input logic [7:0] a, v);
        @(posedge ref_clk_i);
        {wr_i, rd_i, addr_i, wdata_i} <= {w, r, a, v};
    endtask
    // A read notes the word it should return
    task rd(input logic [7:0] a, e);
        bus(1'b0, 1'b1, a, 8'h00);
        q.push_back(e);
    endtask
    // A write to the select register notes the levels it should give
    task wr(input logic [7:0] a, v);
        bus(1'b1, 1'b0, a, v);
        if (a == 8'h00) lq.push_back(v[4:0]);
    endtask
    task chk_lvl(input logic [4:0] e, g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %0t levels %h exp %h", $time, g, e);
        end
    endtask
    task chk(input logic [7:0] e, g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %0t rdata %h exp %h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Read data one cycle after the read; levels two after the write
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc > 900)
        begin
            n_mismatch++;
            end_sim;
        end
        else
        begin
            if (rd_q) chk(q.pop_front(), rdata_o);
            if (wr_q2) chk_lvl(lq.pop_front(), p);
            rd_q <= rd_i;
            wr_q1 <= wr_i && addr_i == 8'h00;
            wr_q2 <= wr_q1;
        end
    end
    initial
    begin
        void'($urandom(48));
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rd(8'h00, 8'h00);
        for (int i = 0; i < 30; i++)
        begin
            d = i == 0 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom);
            wr(8'h00, d);
            wr(8'h08 | 8'($urandom), ~d);
            rd(8'h00, {3'h0, d[4:0]});
            rd(8'h04, {3'h0, d[4:0]});
            rd(8'h08 | 8'($urandom), 8'h00);
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            $display("test %0d done", i);
        end
        repeat (3) @(posedge ref_clk_i);
        end_sim;
    end
endmodule
